// File: pvs_port.sv
// Behaviour
// RULE1 - Receive bit clock and frame sync pins select format and ISDN channel
// RULE2 - GCI only after receive bit clock low for two frame periods
// RULE3 - IDL only after receive bit clock high for two frame periods
// RULE4 - Word and sample instant align to frame sync rising edge
// RULE5 - Frame sync high on two bit clock falling edges means long
// RULE6 - Master keeps frame sync rising edges at a fixed period
// RULE7 - Long frame drives data while sync high or word shifting
// RULE8 - Long frame floats at later of sync fall and half LSB
// RULE9 - Next frame type predicted from previous frame sync
// RULE10 - Data pin floats two frame periods after any power-down
// RULE11 - Sync high on exactly one falling edge means short frame
// RULE12 - Short frame drives first bit on following rising edge
// RULE13 - Short frame floats halfway through the LSB
// RULE14 - Short frame receive starts one falling edge after sync edge
// RULE15 - GCI data changes on clock rising edges, sync aligned
// RULE16 - GCI bit lasts two clocks, B1 then B2 of sixteen clocks
// RULE17 - GCI floats after falling edge sixteen or thirty-two
// RULE18 - IDL transmits B1 on first rising edge, B2 on eleventh
// RULE19 - IDL receives B1 on first falling edge, B2 on eleventh
// RULE20 - IDL floats outside own bits and unused slot
// RULE21 - Prescaler measures master clock per frame, makes 256k and 8k
// RULE22 - Standby when frame sync absent a whole frame, clocks running
// RULE23 - Power-down on low input, resume with sync and guard
// RULE24 - Master clock at two lowest rates kept aligned to sync
// RULE25 - Power-up input high powers up, low powers down
// RULE26 - Samples shift most significant bit first everywhere
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pvs_regs.svh"
module pvs_port (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        master_clock_in,
  input  wire logic        tx_bit_clock_in,
  input  wire logic        tx_frame_sync_in,
  input  wire logic        rx_bit_clock_in,
  input  wire logic        rx_frame_sync_in,
  input  wire logic        serial_rx_data_in,
  input  wire logic        power_up_input_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             serial_tx_data_out,
  output logic             serial_tx_oe_out,
  output logic      [7:0]  rx_sample_out,
  output logic             rx_valid_out,
  output logic             sample_tick_out,
  output logic             tick_256k_out,
  output logic             standby_out,
  output logic             power_down_out,
  output logic      [1:0]  mode_out
);

  // ==========================================================
  // State and pin edges
  pvs_pkg::pvs_st_s s;
  pvs_pkg::pvs_st_s n;
  logic             tr;
  logic             tf;
  logic             rf;
  logic             rbc_chg;
  logic             fs_rise;
  logic             mr;
  logic [5:0]       hrel;

  // Pins are synchronous to the core clock, so one stage is enough
  assign tr      = tx_bit_clock_in & ~s.tbc;
  assign tf      = ~tx_bit_clock_in & s.tbc;
  assign rf      = ~rx_bit_clock_in & s.rbc;
  assign rbc_chg = rx_bit_clock_in ^ s.rbc;
  assign fs_rise = tx_frame_sync_in & ~s.tfs;
  assign mr      = master_clock_in & ~s.mck;
  assign hrel    = s.c - (s.ch ? `PVS_B2_IDL : 6'h00);

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [5:0] nc;
    logic [5:0] rel;
    logic [5:0] w;
    logic [2:0] idx;
    logic [7:0] tw;
    logic       inslot;
    logic       gci;
    logic       take;
    logic       done;
    nc     = s.c;
    rel    = 6'h00;
    w      = 6'h00;
    idx    = 3'h0;
    tw     = s.tsr;
    inslot = 1'b0;
    gci    = (s.mode == pvs_pkg::PVS_GCI);
    take   = 1'b0;
    done   = 1'b0;
    n      = s;
    n.tbc  = tx_bit_clock_in;
    n.tfs  = tx_frame_sync_in;
    n.rbc  = rx_bit_clock_in;
    n.mck  = master_clock_in;
    n.rxv  = 1'b0;
    n.t256 = 1'b0;
    n.t8k  = 1'b0;
    n.ack  = 1'b0;
    n.pd   = ~power_up_input_in; // RULE25 RULE23

    // ========================================================
    // Format detection from the receive clock pin
    if (rbc_chg)
    begin
      n.mode = pvs_pkg::PVS_FRAME; // RULE1
      n.stc  = 2'h0;
    end
    if (fs_rise)
    begin
      n.t8k  = 1'b1; // RULE4
      n.ch   = rx_frame_sync_in; // RULE1
      n.rtog = rbc_chg;
      if (!s.rtog && !rbc_chg)
      begin
        if (s.stc != `PVS_STATIC_FRAMES)
          n.stc = s.stc + 2'h1;
        if (s.stc == `PVS_STATIC_FRAMES - 2'h1)
          n.mode = rx_bit_clock_in ? pvs_pkg::PVS_IDL // RULE3
                                   : pvs_pkg::PVS_GCI; // RULE2
      end
      // Frame length in master clock edges sets the division ratio
      // A master clock edge that coincides with the sync edge still counts
      n.fcnt  = (mr && s.since != `PVS_CNT_SAT) ? s.since + 10'h001 : s.since; // RULE21
      n.since = 10'h000;
      n.pcnt  = 5'h00; // RULE4
      n.sby   = 1'b0;
      if (s.guard != 2'h0 && !s.pd && !s.sby)
        n.guard = s.guard - 2'h1; // RULE10
    end
    else
    begin
      if (rbc_chg)
        n.rtog = 1'b1;
      if (mr)
      begin
        if (s.since != `PVS_CNT_SAT)
          n.since = s.since + 10'h001;
        // Ratio is frame count over 32, which covers all seven rates
        if (5'(s.pcnt + 5'h01) >= s.fcnt[`PVS_DIV_MSB:`PVS_DIV_LSB])
        begin
          n.pcnt = 5'h00;
          n.t256 = 1'b1; // RULE21
        end
        else
          n.pcnt = s.pcnt + 5'h01;
        if (s.fcnt != 10'h000 && s.since == s.fcnt + `PVS_SBY_SLACK)
        begin
          n.sby   = 1'b1; // RULE22
          n.guard = `PVS_GUARD_FRAMES; // RULE10
        end
      end
    end
    if (n.pd)
      n.guard = `PVS_GUARD_FRAMES; // RULE10 RULE23

    // ========================================================
    // Long and short frame formats
    if (s.mode == pvs_pkg::PVS_FRAME)
    begin
      unique case (s.txst)
        pvs_pkg::TX_IDLE:
        begin
          if (fs_rise && s.pred_long)
          begin
            n.txst  = pvs_pkg::TX_SHIFT;
            n.txd   = s.txword[7]; // RULE4 RULE7 RULE26
            n.tsr   = {s.txword[6:0], 1'b0};
            n.tbit  = 3'h0;
            n.txoe  = 1'b1; // RULE7
            n.tlong = 1'b1;
          end
          else if (tf && tx_frame_sync_in && s.thi == 2'h0 && !s.pred_long)
          begin
            n.txst  = pvs_pkg::TX_WAIT; // RULE11
            n.tsr   = s.txword;
            n.tlong = 1'b0;
          end
        end
        pvs_pkg::TX_WAIT:
        begin
          if (tr)
          begin
            n.txst = pvs_pkg::TX_SHIFT;
            n.txd  = s.tsr[7]; // RULE12 RULE26
            n.tsr  = {s.tsr[6:0], 1'b0};
            n.tbit = 3'h0;
            n.txoe = 1'b1; // RULE12
          end
        end
        pvs_pkg::TX_SHIFT:
        begin
          if (tr && s.tbit != `PVS_LSB_BIT)
          begin
            n.tbit = s.tbit + 3'h1;
            n.txd  = s.tsr[7]; // RULE26
            n.tsr  = {s.tsr[6:0], 1'b0};
          end
          else if (tf && s.tbit == `PVS_LSB_BIT)
          begin
            // Falling edge inside the LSB is its halfway point
            if (s.tlong && tx_frame_sync_in)
              n.txst = pvs_pkg::TX_HOLD; // RULE8
            else
            begin
              n.txst = pvs_pkg::TX_IDLE; // RULE13 RULE8
              n.txoe = 1'b0;
            end
          end
        end
        pvs_pkg::TX_HOLD:
        begin
          if (!tx_frame_sync_in)
          begin
            n.txst = pvs_pkg::TX_IDLE; // RULE8
            n.txoe = 1'b0;
          end
        end
      endcase
      if (tf)
      begin
        if (tx_frame_sync_in)
        begin
          if (s.thi != `PVS_LONG_HITS)
            n.thi = s.thi + 2'h1;
        end
        else
        begin
          if (s.thi != 2'h0)
            n.pred_long = (s.thi == `PVS_LONG_HITS); // RULE5 RULE11 RULE9
          n.thi = 2'h0;
        end
      end
      if (rf)
      begin
        if (rx_frame_sync_in && !s.rhi)
        begin
          n.rhi = 1'b1;
          if (s.pred_long)
          begin
            take  = 1'b1;
            n.rxb = `PVS_RX_BITS - 4'h1;
          end
          else
            n.rxb = `PVS_RX_BITS; // RULE14
        end
        else
        begin
          if (!rx_frame_sync_in)
            n.rhi = 1'b0;
          if (s.rxb != 4'h0)
          begin
            take  = 1'b1; // RULE14
            n.rxb = s.rxb - 4'h1;
            done  = (s.rxb == 4'h1);
          end
        end
      end
    end

    // ========================================================
    // ISDN slot formats
    else
    begin
      if (fs_rise)
      begin
        nc    = `PVS_SLOT_PRE;
        n.tsr = s.txword;
        tw    = s.txword;
      end
      // IDL counts rising edges after the sync pulse has ended
      if (tr && (gci || !tx_frame_sync_in) && nc != `PVS_SLOT_SAT)
        nc = nc + 6'h01; // RULE15 RULE18
      n.c = nc;
      if (gci)
      begin
        rel = nc - (s.ch ? `PVS_B2_GCI : 6'h00); // RULE16
        w   = `PVS_W_GCI;
        idx = rel[3:1]; // RULE16
      end
      else
      begin
        rel = nc - (s.ch ? `PVS_B2_IDL : 6'h00); // RULE18 RULE19
        w   = `PVS_W_IDL;
        idx = rel[2:0];
      end
      inslot = (rel < w);
      if (tr)
      begin
        n.txoe = inslot; // RULE20 RULE16
        if (inslot)
          n.txd = tw[3'h7 - idx]; // RULE26 RULE15
      end
      if (tf && rel == w - 6'h01)
        n.txoe = 1'b0; // RULE17 RULE20
      if (gci && tr && inslot && rel[0])
      begin
        take = 1'b1; // RULE16
        done = (rel == `PVS_W_GCI - 6'h01);
      end
      if (!gci && tf && inslot)
      begin
        take = 1'b1; // RULE19
        done = (rel == `PVS_W_IDL - 6'h01);
      end
    end

    if (take)
      n.rsr = {s.rsr[6:0], serial_rx_data_in}; // RULE26
    if (done)
    begin
      n.rxword = {s.rsr[6:0], serial_rx_data_in};
      n.rxv    = 1'b1;
    end
    // Any power-down, standby or guard frame keeps the pin floating
    if (n.pd || n.sby || n.guard != 2'h0)
    begin
      n.txoe = 1'b0; // RULE10 RULE23 RULE22
      n.txst = pvs_pkg::TX_IDLE;
    end

    // ========================================================
    // Register bus; unmapped addresses ack and read zero
    if (wb_cyc_in && wb_stb_in && !s.ack)
    begin
      n.ack = 1'b1;
      n.dat = 32'h0000_0000;
      case (wb_adr_in)
        `PVS_ADR_TXWORD:
        begin
          n.dat = {24'h00_0000, s.txword};
        end
        `PVS_ADR_STATUS:
          n.dat = 32'({s.guard != 2'h0, s.pd, s.sby, s.pred_long,
                       s.ch, s.mode, s.rxword});
        `PVS_ADR_RATIO:
          n.dat = {22'h00_0000, s.fcnt};
        default:
          n.dat = 32'h0000_0000;
      endcase
    end
    // Write lands at the edge at which the master samples ack
    if (s.ack && wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0]
        && wb_adr_in == `PVS_ADR_TXWORD)
      n.txword = wb_dat_in[7:0];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s       <= '0;
      s.guard <= `PVS_GUARD_FRAMES;
    end
    else
      s <= n;
  end

  assign wb_dat_out         = s.dat;
  assign wb_ack_out         = s.ack;
  assign serial_tx_data_out = s.txd;
  assign serial_tx_oe_out   = s.txoe;
  assign rx_sample_out      = s.rxword;
  assign rx_valid_out       = s.rxv;
  assign sample_tick_out    = s.t8k;
  assign tick_256k_out      = s.t256;
  assign standby_out        = s.sby;
  assign power_down_out     = s.pd;
  assign mode_out           = s.mode;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence seq_wb_req;
    wb_cyc_in && wb_stb_in && !s.ack;
  endsequence
  sequence seq_ack_pulse;
    s.ack ##1 !s.ack;
  endsequence
  sequence seq_to_gci;
    s.mode != pvs_pkg::PVS_GCI ##1 s.mode == pvs_pkg::PVS_GCI;
  endsequence
  sequence seq_to_idl;
    s.mode != pvs_pkg::PVS_IDL ##1 s.mode == pvs_pkg::PVS_IDL;
  endsequence

  a_wb_ack_once: assert property (seq_wb_req |=> seq_ack_pulse)
    else $error("bus ack not a single pulse");
  a_pd_float: assert property (!power_up_input_in |=> s.pd && !s.txoe) // RULE25
    else $error("pin driven while powered down");
  a_guard_float: assert property (s.guard != 2'h0 |-> !s.txoe) // RULE10
    else $error("pin driven during guard frames");
  a_gci_entry: assert property (seq_to_gci |-> s.stc == 2'h2 && !s.rbc) // RULE2
    else $error("GCI entered without two static frames");
  a_idl_entry: assert property (seq_to_idl |-> s.stc == 2'h2 && s.rbc) // RULE3
    else $error("IDL entered without two static frames");
  a_long_class: assert property ((tf && !tx_frame_sync_in && s.thi == 2'h2)
    |=> s.pred_long) // RULE5
    else $error("long sync not classified long");
  a_short_class: assert property ((tf && !tx_frame_sync_in && s.thi == 2'h1)
    |=> !s.pred_long) // RULE11
    else $error("short sync not classified short");
  a_short_start: assert property ((s.txst == pvs_pkg::TX_WAIT && tr
    && power_up_input_in && s.guard == 2'h0 && !s.sby
    && s.since != s.fcnt + `PVS_SBY_SLACK)
    |=> s.txoe && s.txst == pvs_pkg::TX_SHIFT) // RULE12
    else $error("short frame did not start driving");
  a_lsb_release: assert property ((s.txst == pvs_pkg::TX_SHIFT
    && s.tbit == 3'h7 && tf && !s.tlong) |=> !s.txoe) // RULE13
    else $error("short frame pin not floated at LSB");
  a_idl_slot: assert property ((s.mode == pvs_pkg::PVS_IDL && s.txoe)
    |-> hrel < 6'h08) // RULE20
    else $error("IDL pin driven outside own slot");
  a_sample_align: assert property (fs_rise |=> s.t8k && s.pcnt == 5'h00) // RULE4
    else $error("sample tick not aligned to sync");

endmodule
`default_nettype wire

// File: pvs_regs.svh
`ifndef PVS_REGS_SVH
`define PVS_REGS_SVH
// ==========================================================
// Register byte offsets
`define PVS_ADR_TXWORD 8'h00
`define PVS_ADR_STATUS 8'h04
`define PVS_ADR_RATIO 8'h08
// ==========================================================
// Frame and slot counts
`define PVS_STATIC_FRAMES 2'h2
`define PVS_GUARD_FRAMES 2'h2
`define PVS_LONG_HITS 2'h2
`define PVS_SBY_SLACK 10'h008
`define PVS_CNT_SAT 10'h3FF
`define PVS_SLOT_SAT 6'h3E
`define PVS_SLOT_PRE 6'h3F
`define PVS_B2_GCI 6'h10
`define PVS_B2_IDL 6'h0A
`define PVS_W_GCI 6'h10
`define PVS_W_IDL 6'h08
`define PVS_LSB_BIT 3'h7
`define PVS_RX_BITS 4'h8
`define PVS_DIV_MSB 9
`define PVS_DIV_LSB 5
`endif

// File: pvs_pkg.sv
`default_nettype none
package pvs_pkg;
  typedef enum logic [1:0] {PVS_FRAME, PVS_GCI, PVS_IDL} pvs_mode_e;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT, TX_HOLD} pvs_tx_e;
  typedef struct packed {
    logic            tbc;
    logic            tfs;
    logic            rbc;
    logic            mck;
    pvs_mode_e       mode;
    logic            ch;
    logic            rtog;
    logic [1:0]      stc;
    logic [1:0]      thi;
    logic            pred_long;
    logic            tlong;
    pvs_tx_e         txst;
    logic [2:0]      tbit;
    logic [7:0]      tsr;
    logic [5:0]      c;
    logic            rhi;
    logic [3:0]      rxb;
    logic [7:0]      rsr;
    logic [7:0]      txword;
    logic [7:0]      rxword;
    logic            rxv;
    logic [9:0]      fcnt;
    logic [9:0]      since;
    logic [4:0]      pcnt;
    logic            t256;
    logic            t8k;
    logic            pd;
    logic            sby;
    logic [1:0]      guard;
    logic            txd;
    logic            txoe;
    logic            ack;
    logic [31:0]     dat;
  } pvs_st_s;
endpackage
`default_nettype wire

// File: pvs_highway.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Highway master: 40 bit clocks of 8 core cycles a frame
module pvs_highway (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] fmt_in,
  input  wire logic       chan_in,
  input  wire logic       sync_on_in,
  input  wire logic [7:0] word_in,
  output logic            bclk_out,
  output logic            fs_out,
  output logic            rbc_out,
  output logic            rfs_out,
  output logic            rxd_out,
  output logic      [5:0] bit_out,
  output logic      [2:0] ph_out,
  output logic      [5:0] off_out,
  output logic            win_out
);
  logic [5:0] base;
  logic       sync;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ph_out  <= 3'h0;
      bit_out <= 6'h00;
    end
    else
    begin
      ph_out <= ph_out + 3'h1;
      if (ph_out == 3'h7)
        bit_out <= (bit_out == 6'h27) ? 6'h00 : bit_out + 6'h01;
    end
  end
  // Formats: 0 short, 1 long, 2 GCI, 3 IDL; master clock is the bit clock
  always_comb
  begin
    bclk_out = (ph_out < 3'h4);
    case (fmt_in)
      2'h0: sync = (bit_out == 6'h27) && (ph_out >= 3'h2);
      2'h1: sync = (bit_out == 6'h00) || ((bit_out == 6'h01) && (ph_out < 3'h6));
      2'h2: sync = (bit_out == 6'h00);
      default: sync = (bit_out == 6'h27);
    endcase
    fs_out = sync && sync_on_in;
    base = !chan_in ? 6'h00 : (fmt_in == 2'h2) ? 6'h10 : (fmt_in == 2'h3) ? 6'h0a : 6'h00;
    off_out = bit_out - base;
    win_out = (bit_out >= base) && (off_out < ((fmt_in == 2'h2) ? 6'h10 : 6'h08));
    rbc_out = (fmt_in == 2'h2) ? 1'b0 : (fmt_in == 2'h3) ? 1'b1 : bclk_out;
    rfs_out = fmt_in[1] ? chan_in : fs_out;
    // Outside the slot the line is released, so it shows a changing pattern
    rxd_out = win_out ? word_in[3'h7 - ((fmt_in == 2'h2) ? off_out[3:1] : off_out[2:0])]
                      : ph_out[0] ^ bit_out[0];
  end
endmodule
`default_nettype wire

// File: pvs_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
module pvs_port_bench;
  logic        clk;
  logic        rst_n;
  logic        pwr_up;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        tx_d;
  logic        tx_oe;
  logic [7:0]  rx_s;
  logic        sby;
  logic        pd;
  logic [1:0]  mode;
  logic [1:0]  fmt;
  logic        chan;
  logic        sync_on;
  logic [7:0]  rx_word;
  logic        bclk;
  logic        fs;
  logic        rbc;
  logic        rfs;
  logic        rxd;
  logic [5:0]  bit_idx;
  logic [2:0]  ph;
  logic [5:0]  off;
  logic        win;
  logic [7:0]  cap;
  logic [7:0]  last_word;
  logic        rxv;
  logic        stk;
  int          rv_cnt;
  int          tk_cnt;
  int          last_rv;
  int          last_tk;
  int          oe_cnt;
  int          last_cnt;
  int          cycles;
  int          err_count;
  int          n_tests;
  logic [31:0] rd;
  event        fdone;

  pvs_highway hw (.clk_in(clk), .rst_n_in(rst_n), .fmt_in(fmt), .chan_in(chan),
    .sync_on_in(sync_on), .word_in(rx_word), .bclk_out(bclk), .fs_out(fs), .rbc_out(rbc),
    .rfs_out(rfs), .rxd_out(rxd), .bit_out(bit_idx), .ph_out(ph), .off_out(off),
    .win_out(win));

  pvs_port dut (.core_clk_in(clk), .rst_n_in(rst_n), .master_clock_in(bclk),
    .tx_bit_clock_in(bclk), .tx_frame_sync_in(fs), .rx_bit_clock_in(rbc),
    .rx_frame_sync_in(rfs), .serial_rx_data_in(rxd), .power_up_input_in(pwr_up),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .serial_tx_data_out(tx_d),
    .serial_tx_oe_out(tx_oe), .rx_sample_out(rx_s), .rx_valid_out(rxv), .sample_tick_out(stk),
    .tick_256k_out(), .standby_out(sby), .power_down_out(pd), .mode_out(mode));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================
  // Transmit capture: one sample per data bit, oe counted over the whole frame
  always @(posedge clk)
  begin
    if (rxv === 1'b1)
      rv_cnt = rv_cnt + 1;
    if (stk === 1'b1)
      tk_cnt = tk_cnt + 1;
    if (ph == 3'h3)
    begin
      if (tx_oe === 1'b1)
        oe_cnt = oe_cnt + 1;
      if (win && (fmt != 2'h2 || off[0]))
        cap = {cap[6:0], tx_d};
    end
    if (bit_idx == 6'h26 && ph == 3'h0)
    begin
      last_word = cap;
      last_cnt = oe_cnt;
      oe_cnt = 0;
      last_rv = rv_cnt;
      rv_cnt = 0;
      last_tk = tk_cnt;
      tk_cnt = 0;
      -> fdone;
    end
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      err_count = err_count + 1;
      give_verdict();
    end
  end

  // ==========================================
  // Tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single cycle; the master holds everything until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic frames(input int n);
    repeat (n) @(fdone);
  endtask

  task automatic run_case(input logic [1:0] f, input logic c, input logic [7:0] txw,
                          input logic [7:0] rxw, input logic [1:0] m);
    fmt <= f;
    chan <= c;
    rx_word <= rxw;
    wb(1'b1, 8'h00, 4'hf, {24'h00_0000, txw});
    frames(4);
    check("mode", {30'h0000_0000, m}, {30'h0000_0000, mode});
    check("tx word", {24'h00_0000, txw}, {24'h00_0000, last_word});
    check("oe bits", (f == 2'h2) ? 16 : 8, last_cnt);
    check("rx word", {24'h00_0000, rxw}, {24'h00_0000, rx_s});
    check("rx valid", 1, last_rv);
    check("sample tick", 1, last_tk);
    $display("test format %0d channel %0d done", f, c);
  endtask

  // ==========================================
  // Sequence
  initial
  begin
    rst_n = 1'b0;
    pwr_up = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    fmt = 2'h0;
    chan = 1'b0;
    sync_on = 1'b1;
    rx_word = 8'h3c;
    {cap, last_word} = 16'h0000;
    {oe_cnt, last_cnt, cycles, err_count, n_tests} = '0;
    {rv_cnt, tk_cnt, last_rv, last_tk} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    frames(2);
    check("guard oe", 32'h0000_0000, last_cnt);
    wb(1'b0, 8'h08, 4'hf, 32'h0000_0000);
    check("ratio", 32'h0000_0028, rd);
    $display("test reset done");
    run_case(2'h0, 1'b0, 8'ha5, 8'h3c, 2'h0);
    wb(1'b0, 8'h04, 4'hf, 32'h0000_0000);
    check("short predicted", 32'h0000_0000, rd & 32'h0000_0800);
    wb(1'b1, 8'h0c, 4'hf, 32'h0000_00ff);
    wb(1'b1, 8'h00, 4'h0, 32'h0000_0011);
    wb(1'b0, 8'h0c, 4'hf, 32'h0000_0000);
    check("unmapped", 32'h0000_0000, rd);
    wb(1'b0, 8'h00, 4'hf, 32'h0000_0000);
    check("txword", 32'h0000_00a5, rd);
    run_case(2'h1, 1'b0, 8'h5a, 8'hc3, 2'h0);
    wb(1'b0, 8'h04, 4'hf, 32'h0000_0000);
    check("long predicted", 32'h0000_0800, rd & 32'h0000_0800);
    run_case(2'h2, 1'b0, 8'h96, 8'h69, 2'h1);
    run_case(2'h2, 1'b1, 8'h81, 8'h7e, 2'h1);
    run_case(2'h3, 1'b0, 8'h0f, 8'hf0, 2'h2);
    run_case(2'h3, 1'b1, 8'he1, 8'h1e, 2'h2);
    run_case(2'h0, 1'b0, 8'hc6, 8'h5b, 2'h0);
    sync_on <= 1'b0;
    frames(2);
    check("standby", 32'h0000_0001, {31'h0000_0000, sby});
    check("standby oe", 32'h0000_0000, last_cnt);
    check("standby tick", 0, last_tk);
    sync_on <= 1'b1;
    frames(1);
    check("wake oe", 32'h0000_0000, last_cnt);
    frames(3);
    check("standby exit", 32'h0000_0000, {31'h0000_0000, sby});
    check("wake word", 32'h0000_00c6, {24'h00_0000, last_word});
    $display("test standby done");
    pwr_up <= 1'b0;
    frames(2);
    check("power down", 32'h0000_0001, {31'h0000_0000, pd});
    check("pd oe", 32'h0000_0000, last_cnt);
    pwr_up <= 1'b1;
    frames(1);
    check("pu guard oe", 32'h0000_0000, last_cnt);
    frames(3);
    check("powered", 32'h0000_0000, {31'h0000_0000, pd});
    check("pu word", 32'h0000_00c6, {24'h00_0000, last_word});
    check("pu oe", 8, last_cnt);
    $display("test power down done");
    give_verdict();
  end
endmodule
`default_nettype wire
